// >>> verilog/bmc_consts.vh
// Constants for the brush motor chopper PWM controller
// How it works
// RQ1 - The drive PWM runs at a fixed 15 kHz and its duty sets motor voltage and speed.
// RQ2 - A zero speed setting holds the PWM output low with no pulses at all.
// RQ3 - Any nonzero speed setting gives a duty between 13 and 100 percent, rising with it.
// RQ4 - Battery level falls into charged, low or discharged, and charged keeps the LED off.
// RQ5 - At or below 90 percent of nominal the LED flashes slowly while the motor still runs.
// RQ6 - At or below 88 percent of nominal the LED flashes fast and the drive stays off.
// RQ7 - Motor current at or above the limit turns the PWM off whatever the speed setting.
// RQ8 - While the current limit holds the drive off, the LED is steadily on.
// RQ9 - Once current falls below the limit, duty follows the setting again and the LED goes off.
// RQ10 - The default current limit is 8 amperes for the 7.2 V motor.
// RQ11 - Setting maps monotonically onto duty, and discharged shutdown beats the user setting.
`ifndef BMC_CONSTS_VH
`define BMC_CONSTS_VH
`define BMC_CLK_HZ 100000000
`define BMC_PWM_HZ 15000
`define BMC_PWM_PERIOD (`BMC_CLK_HZ / `BMC_PWM_HZ)
`define BMC_DUTY_MIN_PCT 13
`define BMC_DUTY_MAX_PCT 100
`define BMC_LOW_PCT 90
`define BMC_DIS_PCT 88
`define BMC_ILIM_DA 80
`define BMC_SLOW_HZ 2
`define BMC_FAST_HZ 8
`define BMC_BATT_CHARGED 2'h0
`define BMC_BATT_LOW 2'h1
`define BMC_BATT_DISCH 2'h2
`endif

// >>> verilog/bmc_blinker.v
// Square-wave blinker for the indicator LED
`default_nettype none
module bmc_blinker #(
   parameter HALF_PERIOD = 6250000
) (
   input wire clk_sys,
   input wire reset_n,
   input wire run,
   output reg blink
);
   reg [31:0] count;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         count <= 32'h0;
         blink <= 1'b0;
      end else if (!run) begin
         count <= 32'h0;
         blink <= 1'b0;
      end else if (count >= HALF_PERIOD - 1) begin
         count <= 32'h0;
         blink <= ~blink;
      end else begin
         count <= count + 32'h1;
      end
   end
endmodule
`default_nettype wire

// >>> verilog/bmc_chopper.v
// Top of the brush motor chopper PWM controller
`include "bmc_consts.vh"
`default_nettype none
module bmc_chopper #(
   parameter SPEED_W = 10,
   parameter BATT_W = 10,
   parameter CUR_W = 10,
   parameter [BATT_W-1:0] BATT_NOMINAL = 10'h3E8,
   parameter [CUR_W-1:0] CUR_PER_DA = 10'h4,
   parameter CLK_HZ = `BMC_CLK_HZ,
   parameter SLOW_HZ = `BMC_SLOW_HZ,
   parameter FAST_HZ = `BMC_FAST_HZ
) (
   input wire clk_sys,
   input wire reset_n,
   input wire [SPEED_W-1:0] speedSetting,
   input wire [BATT_W-1:0] batteryLevel,
   input wire [CUR_W-1:0] motorCurrent,
   output reg pwmOut,
   output reg ledOut,
   output reg [1:0] batteryState,
   output reg currentLimited
);
   localparam PERIOD = `BMC_PWM_PERIOD;
   localparam [31:0] DMIN = (PERIOD * `BMC_DUTY_MIN_PCT + 99) / 100;
   localparam [31:0] SMAX = (1 << SPEED_W) - 1;
   localparam [31:0] LOW_TH = (BATT_NOMINAL * `BMC_LOW_PCT) / 100;
   localparam [31:0] DIS_TH = (BATT_NOMINAL * `BMC_DIS_PCT) / 100;
   localparam [31:0] ILIM = CUR_PER_DA * `BMC_ILIM_DA;

   // Linear map of nonzero setting onto DMIN..PERIOD
   function [31:0] duty_of;
      input [SPEED_W-1:0] s;
      reg [63:0] span;
      begin
         span = 64'h0;
         if (s == {SPEED_W{1'b0}}) begin
            duty_of = 32'h0;
         end else begin
            span = ({32'h0, PERIOD - DMIN}) * ({32'h0, 32'h0 | s} - 64'h1);
            duty_of = DMIN + span[31:0] / (SMAX - 1);
         end
      end
   endfunction

   reg [31:0] phase;
   reg [31:0] dutyLatched;
   reg [1:0] next_batteryState;
   wire slowBlink;
   wire fastBlink;

   always @* begin
      // Battery classification
      if ({22'h0, batteryLevel} <= DIS_TH) begin
         next_batteryState = `BMC_BATT_DISCH;
      end else if ({22'h0, batteryLevel} <= LOW_TH) begin
         next_batteryState = `BMC_BATT_LOW;
      end else begin
         next_batteryState = `BMC_BATT_CHARGED;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         phase <= 32'h0;
         dutyLatched <= 32'h0;
         pwmOut <= 1'b0;
         batteryState <= `BMC_BATT_CHARGED;
         currentLimited <= 1'b0;
      end else begin
         // RQ4 three battery states
         batteryState <= next_batteryState;
         // RQ7 over-current cutoff, RQ9 release below limit, RQ10 8 A default
         currentLimited <= ({22'h0, motorCurrent} >= ILIM);
         // RQ1 fixed 15 kHz period
         if (phase >= PERIOD - 1) begin
            phase <= 32'h0;
            // RQ3 duty 13..100 percent, RQ11 monotonic map; latched per period
            // so a moving pot never glitches mid-cycle
            dutyLatched <= duty_of(speedSetting);
         end else begin
            phase <= phase + 32'h1;
         end
         // RQ2 zero setting, RQ6 discharged stop, RQ11 shutdown wins
         if (speedSetting == {SPEED_W{1'b0}} || dutyLatched == 32'h0
               || batteryState == `BMC_BATT_DISCH || currentLimited) begin
            pwmOut <= 1'b0;
         end else begin
            pwmOut <= (phase < dutyLatched);
         end
      end
   end

   // RQ5 slow flash, RQ6 fast flash
   bmc_blinker #(.HALF_PERIOD(CLK_HZ / (2 * SLOW_HZ))) slowGen (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .run(batteryState == `BMC_BATT_LOW),
      .blink(slowBlink)
   );
   bmc_blinker #(.HALF_PERIOD(CLK_HZ / (2 * FAST_HZ))) fastGen (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .run(batteryState == `BMC_BATT_DISCH),
      .blink(fastBlink)
   );

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ledOut <= 1'b0;
      end else if (currentLimited) begin
         // RQ8 steady on while limited
         ledOut <= 1'b1;
      end else begin
         case (batteryState)
            `BMC_BATT_LOW: ledOut <= slowBlink;
            `BMC_BATT_DISCH: ledOut <= fastBlink;
            // RQ4 charged keeps LED off, RQ9 off after release
            default: ledOut <= 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> tb/bmc_props.sv
// Port checks for the chopper controller
`default_nettype none
module bmc_props (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [9:0] speedSetting,
   input wire logic [9:0] batteryLevel,
   input wire logic [9:0] motorCurrent,
   input wire logic pwmOut,
   input wire logic ledOut,
   input wire logic [1:0] batteryState,
   input wire logic currentLimited
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence overCur;
      motorCurrent >= 10'h140;
   endsequence
   // Limit flag first, then drive off and lamp on
   sequence cutOff;
      currentLimited ##1 (!pwmOut && ledOut);
   endsequence
   AST_ZERO: assert property (speedSetting == 10'h0 |=> !pwmOut) else $error("pulse at zero");
   AST_LIM: assert property (overCur |=> cutOff) else $error("no current cut");
   AST_CLR: assert property (!(motorCurrent >= 10'h140) |=> !currentLimited) else $error("stuck");
   AST_CHG: assert property (batteryState == 2'h0 && !currentLimited |=> !ledOut) else $error("led");
   AST_DIS: assert property (batteryState == 2'h2 |=> !pwmOut) else $error("drive on");
   AST_ST2: assert property (batteryLevel <= 10'h370 |=> batteryState == 2'h2) else $error("s2");
   AST_ST1: assert property (batteryLevel inside {[10'h371:10'h384]} |=> batteryState == 2'h1) else $error("s1");
   AST_ST0: assert property (batteryLevel > 10'h384 |=> batteryState == 2'h0) else $error("s0");
endmodule
bind bmc_chopper bmc_props p_u (.clk_sys, .reset_n, .speedSetting, .batteryLevel, .motorCurrent,
   .pwmOut, .ledOut, .batteryState, .currentLimited);
`default_nettype wire

// >>> tb/bmc_motor_model.sv
// Switch and motor stand-in for the current reading
`default_nettype none
module bmc_motor_model (
   input wire logic pwmOut,
   input wire logic stall,
   output logic [9:0] motorCurrent
);
   // A blocked rotor draws exactly the limit, running draw stays well below
   assign motorCurrent = stall ? 10'h140 : (pwmOut ? 10'h3C : 10'h0);
endmodule
`default_nettype wire

// >>> tb/tb_brush_motor_chopper_pwm_control.sv
// Testbench for the chopper controller
`default_nettype none
module tb_brush_motor_chopper_pwm_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, reset_n = 0, stall = 0, pwmOut, ledOut, currentLimited;
   logic [9:0] speedSetting = 0, batteryLevel = 10'h3E8, motorCurrent;
   logic [1:0] batteryState;
   int n_errors = 0, checks = 0;
   always #5 clk_sys = ~clk_sys;
   // Lowered clock figure only shortens the lamp flash periods
   bmc_chopper #(.CLK_HZ(1000)) dut_u (.clk_sys, .reset_n, .speedSetting, .batteryLevel,
      .motorCurrent, .pwmOut, .ledOut, .batteryState, .currentLimited);
   bmc_motor_model m_u (.pwmOut, .stall, .motorCurrent);
   task chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Four-state counters so an unknown drive level cannot count as a clean zero
   task cnt(input int n, output logic [15:0] hi, output logic [15:0] up);
      logic p;
      hi = 0;
      up = 0;
      repeat (n) begin
         p = ledOut;
         @(posedge clk_sys);
         #1;
         hi += pwmOut;
         up += ledOut & ~p;
      end
   endtask
   task duty(input logic [9:0] s, input int e);
      logic [15:0] hi, up;
      speedSetting = s;
      cnt(6667, hi, up);
      cnt(6666, hi, up);
      chk(hi, e);
   endtask
   task t_duty;
      duty(10'h0, 0);
      duty(10'h1, 867);
      duty(10'h200, 3766);
      duty(10'h3FF, 6666);
   endtask
   task t_period;
      logic [15:0] hi, up;
      int n;
      speedSetting = 10'h1;
      cnt(6667, hi, up);
      while (pwmOut !== 1'b0) begin
         cnt(1, hi, up);
      end
      while (pwmOut !== 1'b1) begin
         cnt(1, hi, up);
      end
      n = 0;
      while (pwmOut === 1'b1) begin
         cnt(1, hi, up);
         n++;
      end
      while (pwmOut === 1'b0) begin
         cnt(1, hi, up);
         n++;
      end
      chk(n, 6666);
   endtask
   task t_limit;
      logic [15:0] hi, up;
      stall = 1;
      cnt(3, hi, up);
      chk({currentLimited, pwmOut, ledOut}, 3'h5);
      stall = 0;
      cnt(3, hi, up);
      chk({currentLimited, pwmOut, ledOut}, 3'h2);
   endtask
   task t_batt;
      logic [15:0] hi, up;
      batteryLevel = 10'h384;
      cnt(1000, hi, up);
      chk({batteryState, up[3:0], hi > 0}, 7'h25);
      batteryLevel = 10'h370;
      cnt(3, hi, up);
      cnt(992, hi, up);
      chk({batteryState, up[3:0], hi > 0}, 7'h50);
      batteryLevel = 10'h3E8;
      cnt(3, hi, up);
      chk({batteryState, ledOut}, 3'h0);
   endtask
   task end_of_test;
      $display("checks=%0d errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #1000000;
      n_errors++;
      end_of_test;
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      #1 reset_n = 1;
      chk({pwmOut, ledOut, batteryState, currentLimited}, 16'h0);
      t_period;
      t_duty;
      t_limit;
      t_batt;
      end_of_test;
   end
endmodule
`default_nettype wire
